/* design/guard_defines.svh */
/*
  Offsets, field positions, reset values and counts of the security guard.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef GUARD_DEFINES_SVH
`define GUARD_DEFINES_SVH

// register offsets on the plain register port
`define REG_FLAGS 8'h00
`define REG_REACT 8'h01
`define REG_CAUSE 8'h02
`define REG_CTRL 8'h03
`define REG_STATUS 8'h04
`define REG_CSUM 8'h05
`define REG_BASE0 8'h10
`define REG_LIMIT0 8'h20
`define REG_ATTR0 8'h30

// detector bit order: freq, volt, temp, light, insulation, shield, glitch
`define DET_N 7
// detectors whose reaction is always a chip reset
`define DET_FORCED_RESET 7'h47
// detectors that count as physical tampering
`define DET_TAMPER 7'h38
`define REACT_RESET_VAL 7'h7f

// fast interrupt cause bits
`define CAUSE_N 5
`define CAUSE_INVALID 0
`define CAUSE_EE_EXEC 1
`define CAUSE_MPU 2
`define CAUSE_SECREG 3
`define CAUSE_TAMPER 4

// region attribute bits: user read, user write, user execute; control bit: user eeprom execute
`define ATTR_R 0
`define ATTR_W 1
`define ATTR_X 2
`define CTRL_EE_UEXEC 0

// status fields
`define STAT_PRIV 0
`define STAT_TEST_LSB 1

`endif

/* design/guard_pkg.sv */
/*
  Types shared by the security guard: test access states and commands.
  Assumes nothing of its surroundings.
*/
package guard_pkg;

  typedef enum logic [1:0] {
    TST_LOCKED = 2'b00,
    TST_OPEN = 2'b01,
    TST_NORMAL = 2'b10
  } test_state_t;

  typedef enum logic [2:0] {
    CMD_AUTH = 3'b000,
    CMD_TRACE = 3'b001,
    CMD_CSUM_CLR = 3'b010,
    CMD_CSUM_ADD = 3'b011,
    CMD_CSUM_RD = 3'b100,
    CMD_LEAVE = 3'b101
  } test_cmd_t;

endpackage : guard_pkg

/* design/security_alarm_and_access_guard.sv */
/*
  Chip-level security supervisor: detector events, clock and reset
  filters, access traps with a fast interrupt, memory protection unit,
  and the one-way test mode gate.
  Assumes one clock, inputs synchronous to it, i_srst as power-on reset,
  and a nonvolatile normal-mode fuse that reads back on i_fuse_normal.
*/
// Function
// - every detector event is latched into a readable flag register
// - software picks per light, insulation and shield detector: immediate chip reset or flag with fast interrupt
// - seven detector inputs: freq, volt, temp, light, insulation, shield, glitch
// - frequency, voltage, temperature and glitch failures always reset the chip
// - external clock and reset inputs pass a stability filter
// - software cannot touch filters or detection, only the reaction
// - tamper detection halts work by chip reset or fast interrupt
// - security registers accept access only in privileged mode
// - access to an invalid address raises the fast interrupt
// - forbidden execution from the eeprom raises the fast interrupt
// - any access to a prohibited area is trapped
// - privileged and user modes steer every access decision except the invalid-address trap
// - power-on reset loads all registers with defaults
// - privileged software sets regions; user accesses limited to them
// - leaving test mode for normal mode is permanent
// - test access requires a password first
// - normal mode rejects every test command
// - test mode writes traceability data once to nonvolatile memory
// - test mode computes a checksum over embedded code words
`timescale 1ns/1ps
`default_nettype none
`include "guard_defines.svh"

module security_alarm_and_access_guard #(
  parameter int NREG = 4,
  parameter int FILT_LEN = 4,
  parameter int RST_HOLD = 8,
  parameter int TRACE_WORDS = 16,
  parameter logic [15:0] MEM_TOP = 16'hbfff,
  parameter logic [15:0] EE_BASE = 16'h8000,
  parameter logic [15:0] EE_TOP = 16'hbfff,
  // arbitrary value, replace per product
  parameter logic [15:0] PASSWORD = 16'h5a3c
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [`DET_N-1:0] i_det,
  input wire logic i_ext_clk,
  input wire logic i_ext_rst,
  input wire logic i_priv,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_bus_valid,
  input wire logic [15:0] i_bus_addr,
  input wire logic i_bus_write,
  input wire logic i_bus_fetch,
  input wire logic i_fuse_normal,
  input wire logic i_tst_valid,
  input wire logic [2:0] i_tst_cmd,
  input wire logic [15:0] i_tst_data,
  output logic o_tst_ack,
  output logic o_tst_ok,
  output logic [15:0] o_tst_rdata,
  output logic o_nvm_we,
  output logic [7:0] o_nvm_addr,
  output logic [15:0] o_nvm_data,
  output logic o_fuse_burn,
  output logic o_test_mode,
  output logic o_ext_clk_filt,
  output logic o_ext_rst_filt,
  output logic o_chip_reset,
  output logic [`CAUSE_N-1:0] o_fast_interrupt_cause,
  output logic o_fast_interrupt_request
);

  // elaboration checks
  if (NREG < 1 || NREG > 16) begin : g_nreg_chk
    $error("NREG must lie in 1..16");
  end
  if (FILT_LEN < 1 || FILT_LEN > 255) begin : g_filt_chk
    $error("FILT_LEN must lie in 1..255");
  end
  if (RST_HOLD < 1 || RST_HOLD > 255) begin : g_rst_chk
    $error("RST_HOLD must lie in 1..255");
  end
  if (TRACE_WORDS < 1 || TRACE_WORDS > 255) begin : g_trace_chk
    $error("TRACE_WORDS must lie in 1..255");
  end

  localparam logic [7:0] FILT_CNT = 8'(FILT_LEN);
  localparam logic [7:0] HOLD_CNT = 8'(RST_HOLD);
  localparam logic [7:0] TRACE_MAX = 8'(TRACE_WORDS);

  typedef struct packed {
    guard_pkg::test_state_t tst;
    logic [`DET_N-1:0] flags;
    logic [`DET_N-1:0] react;
    logic [`CAUSE_N-1:0] cause;
    logic ee_uexec;
    logic [NREG-1:0][15:0] base;
    logic [NREG-1:0][15:0] limit;
    logic [NREG-1:0][2:0] attr;
    logic [15:0] csum;
    logic [7:0] tcnt;
    logic [15:0] rdata;
    logic fast_interrupt_request;
    logic [7:0] rcnt;
    logic chip_rst;
    logic clk_f;
    logic rst_f;
    logic [7:0] ccnt;
    logic [7:0] xcnt;
    logic ack;
    logic ok;
    logic [15:0] trdata;
    logic nvm_we;
    logic [7:0] nvm_addr;
    logic [15:0] nvm_data;
    logic fuse_burn;
  } state_t;

  state_t q;
  state_t next_q;

  // true when lo <= a <= hi
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // next count of a stability filter; the caller flips on reaching len
  function automatic logic [7:0] filt_step(input logic raw, input logic cur,
                                           input logic [7:0] cnt);
    if (raw == cur) begin
      filt_step = 8'h00;
    end else begin
      filt_step = cnt + 8'h01;
    end
  endfunction : filt_step

  // true when a lies inside a bank of NREG words starting at off
  function automatic logic bank_hit(input logic [7:0] a, input logic [7:0] off);
    bank_hit = (a >= off) && (a < off + 8'(NREG));
  endfunction : bank_hit

  always_comb
  begin
    logic [`DET_N-1:0] flag_clr;
    logic [`CAUSE_N-1:0] cause_set;
    logic [`CAUSE_N-1:0] cause_clr;
    logic [`DET_N-1:0] to_reset;
    logic [3:0] idx;
    logic user_ok;
    logic sec_ok;
    logic [7:0] cc;
    logic [7:0] xc;
    flag_clr = '0;
    cause_set = '0;
    cause_clr = '0;
    to_reset = '0;
    idx = '0;
    user_ok = 1'b0;
    sec_ok = 1'b0;
    cc = 8'h00;
    xc = 8'h00;
    next_q = q;
    next_q.rdata = 16'h0000;
    next_q.ack = 1'b0;
    next_q.ok = 1'b0;
    next_q.nvm_we = 1'b0;
    next_q.fuse_burn = 1'b0;

    // privilege gate
    // security registers only for privileged code
    sec_ok = i_priv;
    if ((i_wr || i_rd) && !sec_ok) begin
      cause_set[`CAUSE_SECREG] = 1'b1;
    end

    // register writes; detector and filter logic has no write path at all
    if (i_wr && sec_ok) begin
      idx = i_addr[3:0];
      case (i_addr)
        `REG_FLAGS: flag_clr = i_wdata[`DET_N-1:0];
        // reaction only
        // forced-reset detectors cannot be turned into flag-only
        `REG_REACT: next_q.react = i_wdata[`DET_N-1:0] | `DET_FORCED_RESET;
        `REG_CAUSE: cause_clr = i_wdata[`CAUSE_N-1:0];
        `REG_CTRL: next_q.ee_uexec = i_wdata[`CTRL_EE_UEXEC];
        default:
        begin
          // region setup
          // privileged software defines the partitions
          if (bank_hit(i_addr, `REG_BASE0)) begin
            next_q.base[idx] = i_wdata;
          end else if (bank_hit(i_addr, `REG_LIMIT0)) begin
            next_q.limit[idx] = i_wdata;
          end else if (bank_hit(i_addr, `REG_ATTR0)) begin
            next_q.attr[idx] = i_wdata[2:0];
          end
        end
      endcase
    end

    // read data stands in the cycle after the strobe; unmapped reads zero
    if (i_rd && sec_ok) begin
      idx = i_addr[3:0];
      case (i_addr)
        `REG_FLAGS: next_q.rdata = 16'(q.flags);
        `REG_REACT: next_q.rdata = 16'(q.react);
        `REG_CAUSE: next_q.rdata = 16'(q.cause);
        `REG_CTRL: next_q.rdata = 16'(q.ee_uexec);
        `REG_STATUS: next_q.rdata = 16'({q.tst, i_priv});
        `REG_CSUM: next_q.rdata = q.csum;
        default:
        begin
          if (bank_hit(i_addr, `REG_BASE0)) begin
            next_q.rdata = q.base[idx];
          end else if (bank_hit(i_addr, `REG_LIMIT0)) begin
            next_q.rdata = q.limit[idx];
          end else if (bank_hit(i_addr, `REG_ATTR0)) begin
            next_q.rdata = 16'(q.attr[idx]);
          end
        end
      endcase
    end

    // mode decides
    // privileged accesses pass the region check; user accesses need a matching region
    for (int i = 0; i < NREG; i++) begin
      if (in_range(i_bus_addr, q.base[i], q.limit[i])) begin
        if (i_bus_fetch ? q.attr[i][`ATTR_X]
            : (i_bus_write ? q.attr[i][`ATTR_W] : q.attr[i][`ATTR_R])) begin
          user_ok = 1'b1;
        end
      end
    end
    if (i_bus_valid) begin
      if (i_bus_addr > MEM_TOP) begin
        cause_set[`CAUSE_INVALID] = 1'b1;
      end
      if (i_bus_fetch && !i_priv && !q.ee_uexec
          && in_range(i_bus_addr, EE_BASE, EE_TOP)) begin
        cause_set[`CAUSE_EE_EXEC] = 1'b1;
      end
      if (!i_priv && !user_ok) begin
        cause_set[`CAUSE_MPU] = 1'b1;
      end
    end

    next_q.flags = (q.flags & ~flag_clr) | i_det;

    to_reset = i_det & q.react;
    // tamper in flag mode halts by interrupt instead
    if ((i_det & `DET_TAMPER & ~q.react) != '0) begin
      cause_set[`CAUSE_TAMPER] = 1'b1;
    end

    // causes are sticky, new trap beats software clear
    next_q.cause = (q.cause & ~cause_clr) | cause_set;
    next_q.fast_interrupt_request = next_q.cause != '0;

    // clock and reset filters
    // a level must hold FILT_LEN cycles; faster toggling never passes
    cc = filt_step(i_ext_clk, q.clk_f, q.ccnt);
    if (cc >= FILT_CNT) begin
      next_q.clk_f = i_ext_clk;
      cc = 8'h00;
    end
    next_q.ccnt = cc;
    xc = filt_step(i_ext_rst, q.rst_f, q.xcnt);
    if (xc >= FILT_CNT) begin
      next_q.rst_f = i_ext_rst;
      xc = 8'h00;
    end
    next_q.xcnt = xc;

    // chip reset stretched so a one-cycle event still clears the chip
    if (to_reset != '0 || next_q.rst_f) begin
      next_q.rcnt = HOLD_CNT;
    end else if (q.rcnt != 8'h00) begin
      next_q.rcnt = q.rcnt - 8'h01;
    end
    next_q.chip_rst = next_q.rcnt != 8'h00;

    // fuse keeps normal mode across every reset
    if (i_fuse_normal) begin
      next_q.tst = guard_pkg::TST_NORMAL;
    end

    // test port; each command answered one cycle later
    if (i_tst_valid) begin
      next_q.ack = 1'b1;
      case (q.tst)
        guard_pkg::TST_LOCKED:
        begin
          if (i_tst_cmd == guard_pkg::CMD_AUTH && i_tst_data == PASSWORD
              && !i_fuse_normal) begin
            next_q.tst = guard_pkg::TST_OPEN;
            next_q.ok = 1'b1;
          end
        end
        guard_pkg::TST_OPEN:
        begin
          next_q.ok = 1'b1;
          case (i_tst_cmd)
            guard_pkg::CMD_AUTH: next_q.ok = 1'b1;
            guard_pkg::CMD_TRACE:
            begin
              if (q.tcnt < TRACE_MAX) begin
                next_q.nvm_we = 1'b1;
                next_q.nvm_addr = q.tcnt;
                next_q.nvm_data = i_tst_data;
                next_q.tcnt = q.tcnt + 8'h01;
              end else begin
                next_q.ok = 1'b0;
              end
            end
            guard_pkg::CMD_CSUM_CLR: next_q.csum = 16'h0000;
            guard_pkg::CMD_CSUM_ADD: next_q.csum = q.csum + i_tst_data;
            guard_pkg::CMD_CSUM_RD: next_q.trdata = q.csum;
            guard_pkg::CMD_LEAVE:
            begin
              next_q.tst = guard_pkg::TST_NORMAL;
              next_q.fuse_burn = 1'b1;
            end
            default: next_q.ok = 1'b0;
          endcase
        end
        guard_pkg::TST_NORMAL: next_q.ok = 1'b0;
        default: next_q.tst = guard_pkg::TST_NORMAL;
      endcase
    end
  end

  // single state register
  always_ff @(posedge i_mclk)
  begin
    if (i_srst) begin
      q <= '0;
      q.tst <= guard_pkg::TST_LOCKED;
      q.react <= `REACT_RESET_VAL;
    end else begin
      q <= next_q;
    end
  end

  // outputs all straight from the state register
  assign o_rdata = q.rdata;
  assign o_tst_ack = q.ack;
  assign o_tst_ok = q.ok;
  assign o_tst_rdata = q.trdata;
  assign o_nvm_we = q.nvm_we;
  assign o_nvm_addr = q.nvm_addr;
  assign o_nvm_data = q.nvm_data;
  assign o_fuse_burn = q.fuse_burn;
  assign o_test_mode = q.tst == guard_pkg::TST_OPEN;
  assign o_ext_clk_filt = q.clk_f;
  assign o_ext_rst_filt = q.rst_f;
  assign o_chip_reset = q.chip_rst;
  assign o_fast_interrupt_cause = q.cause;
  assign o_fast_interrupt_request = q.fast_interrupt_request;

endmodule : security_alarm_and_access_guard
`default_nettype wire

/* sim/guard_assertions.sv */
/*
  Port checker of the security guard.
  Assumes binding into the guard top and the default parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module guard_assertions #(
  parameter logic [15:0] PASSWORD = 16'h5a3c,
  parameter logic [15:0] MEM_TOP = 16'hbfff
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [6:0] i_det,
  input wire logic i_ext_clk,
  input wire logic i_priv,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_bus_valid,
  input wire logic [15:0] i_bus_addr,
  input wire logic i_fuse_normal,
  input wire logic i_tst_valid,
  input wire logic [2:0] i_tst_cmd,
  input wire logic [15:0] i_tst_data,
  input wire logic o_tst_ack,
  input wire logic o_tst_ok,
  input wire logic o_fuse_burn,
  input wire logic o_test_mode,
  input wire logic o_ext_clk_filt,
  input wire logic o_chip_reset,
  input wire logic [4:0] o_fast_interrupt_cause,
  input wire logic o_fast_interrupt_request
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  property p_force_rst;
    (|(i_det & 7'h47)) |=> o_chip_reset;
  endproperty
  a_force_rst: assert property (p_force_rst) else $error("no reset on failure");
  property p_stretch;
    $rose(o_chip_reset) |-> o_chip_reset [*7];
  endproperty
  a_stretch: assert property (p_stretch) else $error("reset too short");
  property p_invalid;
    i_bus_valid && (i_bus_addr > MEM_TOP) |=> o_fast_interrupt_cause[0];
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid access missed");
  property p_irq;
    (|o_fast_interrupt_cause) |-> ##[0:1] o_fast_interrupt_request;
  endproperty
  a_irq: assert property (p_irq) else $error("cause without request");
  property p_secreg;
    (i_wr || i_rd) && !i_priv |=> o_fast_interrupt_cause[3];
  endproperty
  a_secreg: assert property (p_secreg) else $error("user register access missed");
  property p_bad_pw;
    i_tst_valid && (i_tst_cmd == guard_pkg::CMD_AUTH) && (i_tst_data != PASSWORD)
      && !o_test_mode |=> !o_tst_ok;
  endproperty
  a_bad_pw: assert property (p_bad_pw) else $error("wrong password taken");
  property p_ack;
    i_tst_valid |=> o_tst_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("test command not answered");
  property p_normal;
    i_fuse_normal && $past(i_fuse_normal) && i_tst_valid |=> !o_tst_ok;
  endproperty
  a_normal: assert property (p_normal) else $error("test command in normal mode");
  property p_burn;
    o_fuse_burn |-> o_tst_ack && !o_test_mode;
  endproperty
  a_burn: assert property (p_burn) else $error("test mode after leave");
  property p_filt;
    $changed(o_ext_clk_filt) |-> ($past(i_ext_clk, 1) == o_ext_clk_filt)
      && ($past(i_ext_clk, 3) == o_ext_clk_filt);
  endproperty
  a_filt: assert property (p_filt) else $error("filter followed a glitch");
  property p_rst_dflt;
    $past(i_srst) |-> !o_chip_reset && !o_test_mode && (o_fast_interrupt_cause == 5'h00);
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("outputs not at default");
endmodule : guard_assertions

bind security_alarm_and_access_guard guard_assertions #(.PASSWORD(PASSWORD),
  .MEM_TOP(MEM_TOP)) u_chk (
  .i_mclk, .i_srst, .i_det, .i_ext_clk, .i_priv, .i_wr, .i_rd, .i_bus_valid, .i_bus_addr,
  .i_fuse_normal, .i_tst_valid, .i_tst_cmd, .i_tst_data, .o_tst_ack, .o_tst_ok, .o_fuse_burn,
  .o_test_mode, .o_ext_clk_filt, .o_chip_reset, .o_fast_interrupt_cause,
  .o_fast_interrupt_request
);
`default_nettype wire

/* sim/guard_sensor_model.sv */
/*
  Model of the on-chip sensors feeding the guard.
  Assumes the bench names which sensors fire each cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module guard_sensor_model (
  input wire logic i_mclk,
  input wire logic [6:0] i_fire,
  output logic [6:0] o_det = 7'h00
);
  always_ff @(posedge i_mclk)
  begin
    o_det <= i_fire;
  end
endmodule : guard_sensor_model
`default_nettype wire

/* sim/test_security_alarm_and_access_guard.sv */
/*
  Self-checking bench of the security guard.
  Assumes default parameters and the sensor model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_security_alarm_and_access_guard;
  typedef struct packed {logic p; logic [15:0] a; logic w; logic f; logic [4:0] e;} row_t;
  logic i_mclk = 0, i_srst = 1, i_ext_clk = 0, i_ext_rst = 0, i_priv = 1, i_wr = 0, i_rd = 0;
  logic i_bus_valid = 0, i_bus_write = 0, i_bus_fetch = 0, i_fuse_normal = 0, i_tst_valid = 0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000, i_bus_addr = 16'h0000, i_tst_data = 16'h0000;
  logic [2:0] i_tst_cmd = 3'h0;
  logic [6:0] fire = 7'h00, i_det;
  logic [15:0] o_rdata, o_tst_rdata, o_nvm_data;
  logic [7:0] o_nvm_addr;
  logic [4:0] o_fast_interrupt_cause;
  logic o_tst_ack, o_tst_ok, o_nvm_we, o_fuse_burn, o_test_mode, o_ext_clk_filt;
  logic o_ext_rst_filt, o_chip_reset, o_fast_interrupt_request;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  // region 0 read only, region 1 read and execute
  row_t rows [7] = '{'{1'b1, 16'hc000, 1'b0, 1'b0, 5'h01}, '{1'b0, 16'h0100, 1'b0, 1'b0, 5'h00},
    '{1'b0, 16'h0100, 1'b1, 1'b0, 5'h04}, '{1'b1, 16'h0100, 1'b1, 1'b0, 5'h00},
    '{1'b0, 16'h8100, 1'b0, 1'b1, 5'h02}, '{1'b1, 16'h8100, 1'b0, 1'b1, 5'h00},
    '{1'b0, 16'h2000, 1'b0, 1'b0, 5'h04}};

  guard_sensor_model u_sensors (.i_mclk, .i_fire(fire), .o_det(i_det));
  security_alarm_and_access_guard u_dut (.i_mclk, .i_srst, .i_det, .i_ext_clk, .i_ext_rst,
    .i_priv, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_bus_valid, .i_bus_addr, .i_bus_write,
    .i_bus_fetch, .i_fuse_normal, .i_tst_valid, .i_tst_cmd, .i_tst_data, .o_tst_ack, .o_tst_ok,
    .o_tst_rdata, .o_nvm_we, .o_nvm_addr, .o_nvm_data, .o_fuse_burn, .o_test_mode,
    .o_ext_clk_filt, .o_ext_rst_filt, .o_chip_reset, .o_fast_interrupt_cause,
    .o_fast_interrupt_request);

  initial forever #20 i_mclk = ~i_mclk;

  task automatic tally_and_finish;
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd

  // one memory access, cause check, then clear all causes
  task automatic acc(input row_t r);
    @(posedge i_mclk);
    i_priv <= r.p;
    i_bus_valid <= 1'b1;
    i_bus_addr <= r.a;
    i_bus_write <= r.w;
    i_bus_fetch <= r.f;
    @(posedge i_mclk);
    i_bus_valid <= 1'b0;
    i_priv <= 1'b1;
    #1 chk({11'h000, o_fast_interrupt_cause}, {11'h000, r.e});
    wr(8'h02, 16'h001f);
  endtask : acc

  task automatic tst(input logic [2:0] c, input logic [15:0] d, input logic ok);
    @(posedge i_mclk);
    i_tst_valid <= 1'b1;
    i_tst_cmd <= c;
    i_tst_data <= d;
    @(posedge i_mclk);
    i_tst_valid <= 1'b0;
    #1 chk({14'h0000, o_tst_ack, o_tst_ok}, {14'h0000, 1'b1, ok});
  endtask : tst

  // short sensor pulse, then wait out the reset stretch
  task automatic pulse(input logic [6:0] b, input logic e);
    @(posedge i_mclk);
    fire <= b;
    @(posedge i_mclk);
    fire <= 7'h00;
    @(posedge i_mclk);
    #1 chk({15'h0000, o_chip_reset}, {15'h0000, e});
    repeat (12) @(posedge i_mclk);
  endtask : pulse

  // hang guard, far above the few hundred cycles needed
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd(8'h01, 16'h007f);
    rd(8'h04, 16'h0001);
    rd(8'h7f, 16'h0000);
    wr(8'h10, 16'h0000);
    wr(8'h20, 16'h0fff);
    wr(8'h30, 16'h0001);
    wr(8'h11, 16'h8000);
    wr(8'h21, 16'hbfff);
    wr(8'h31, 16'h0005);
    rd(8'h31, 16'h0005);
    for (int i = 0; i < 7; i++)
      acc(rows[i]);
    wr(8'h03, 16'h0001);
    acc(row_t'{1'b0, 16'h8100, 1'b0, 1'b1, 5'h00});
    i_priv <= 1'b0;
    wr(8'h01, 16'h0000);
    rd(8'h01, 16'h0000);
    chk({11'h000, o_fast_interrupt_cause}, 16'h0008);
    @(posedge i_mclk);
    i_priv <= 1'b1;
    rd(8'h01, 16'h007f);
    wr(8'h02, 16'h001f);
    wr(8'h01, 16'h0000);
    rd(8'h01, 16'h0047);
    pulse(7'h08, 1'b0);
    rd(8'h00, 16'h0008);
    chk({11'h000, o_fast_interrupt_cause}, 16'h0010);
    chk({15'h0000, o_fast_interrupt_request}, 16'h0001);
    @(posedge i_mclk);
    fire <= 7'h08;
    wr(8'h00, 16'h0008);
    rd(8'h00, 16'h0008);
    @(posedge i_mclk);
    fire <= 7'h00;
    wr(8'h00, 16'h0008);
    rd(8'h00, 16'h0000);
    wr(8'h01, 16'h0008);
    pulse(7'h08, 1'b1);
    pulse(7'h01, 1'b1);
    pulse(7'h02, 1'b1);
    pulse(7'h04, 1'b1);
    pulse(7'h40, 1'b1);
    i_ext_clk <= 1'b1;
    @(posedge i_mclk);
    i_ext_clk <= 1'b0;
    repeat (8) @(posedge i_mclk);
    #1 chk({15'h0000, o_ext_clk_filt}, 16'h0000);
    @(posedge i_mclk);
    i_ext_clk <= 1'b1;
    i_ext_rst <= 1'b1;
    repeat (8) @(posedge i_mclk);
    #1 chk({14'h0000, o_ext_clk_filt, o_ext_rst_filt}, 16'h0003);
    chk({15'h0000, o_chip_reset}, 16'h0001);
    @(posedge i_mclk);
    i_ext_rst <= 1'b0;
    tst(3'h1, 16'h0000, 1'b0);
    tst(3'h0, 16'h1111, 1'b0);
    tst(3'h0, 16'h5a3c, 1'b1);
    tst(3'h1, 16'h1234, 1'b1);
    chk(o_nvm_data, 16'h1234);
    chk({7'h00, o_nvm_we, o_nvm_addr}, 16'h0100);
    // fill the rest of the write-once area, then one more must be refused
    repeat (15) tst(3'h1, 16'h0000, 1'b1);
    tst(3'h1, 16'h0000, 1'b0);
    tst(3'h2, 16'h0000, 1'b1);
    tst(3'h3, 16'hfff0, 1'b1);
    tst(3'h3, 16'h0020, 1'b1);
    tst(3'h4, 16'h0000, 1'b1);
    chk(o_tst_rdata, 16'h0010);
    tst(3'h6, 16'h0000, 1'b0);
    tst(3'h5, 16'h0000, 1'b1);
    chk({14'h0000, o_fuse_burn, o_test_mode}, 16'h0002);
    tst(3'h0, 16'h5a3c, 1'b0);
    tst(3'h1, 16'h0000, 1'b0);
    @(posedge i_mclk);
    i_fuse_normal <= 1'b1;
    i_srst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd(8'h04, 16'h0005);
    tst(3'h0, 16'h5a3c, 1'b0);
    tally_and_finish();
  end
endmodule : test_security_alarm_and_access_guard
`default_nettype wire
